// *** verilog/translator_panel_control.sv ***
// operator panel control and status logic of the translator unit
`timescale 1ns/10ps
module translator_panel_control #(
	parameter int STARTUP_CYCLES = panel_pkg::STARTUP_CYCLES
) (
	input  wire logic                                   sys_clk,
	input  wire logic                                   reset,
	input  wire logic                                   clk_en,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [7:0]                             paddr,
	input  wire logic [31:0]                            pwdata,
	output logic      [31:0]                            prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic [panel_pkg::KEY_COUNT-1:0]        plugboard_option_key,
	output logic      [panel_pkg::HUB_COUNT-1:0]        option_hub,
	input  wire logic [panel_pkg::LAMP_COUNT-1:0]       lamp_hub,
	output logic      [panel_pkg::LAMP_COUNT-1:0]       programmable_lamp,
	input  wire logic                                   stop_press,
	input  wire logic                                   launch_press,
	input  wire logic                                   local_clear_press,
	input  wire logic                                   joint_clear_press,
	input  wire panel_pkg::power_mode_t                 power_mode,
	input  wire panel_pkg::char_check_t                 char_check,
	output logic                                        launch_lamp,
	output logic                                        cycle_run,
	output logic                                        joint_clear_lamp,
	output logic                                        io_clear,
	output logic                                        input_ready,
	output logic                                        output_ready,
	output logic                                        compare_lamp,
	output logic                                        untranslatable_flag,
	output logic                                        parity_fault,
	output logic                                        irq
);

	localparam int SW = 4 + panel_pkg::KEY_COUNT + panel_pkg::LAMP_COUNT + $bits(panel_pkg::power_mode_t)
		+ $bits(panel_pkg::char_check_t);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [SW-1:0]                        pins_raw;
	logic [SW-1:0]                        pins_s;
	logic [panel_pkg::KEY_COUNT-1:0]      keys_s;
	logic [panel_pkg::LAMP_COUNT-1:0]     lamps_s;
	logic                                 stop_s;
	logic                                 launch_s;
	logic                                 local_s;
	logic                                 joint_s;
	panel_pkg::power_mode_t               pm_s;
	panel_pkg::char_check_t               cc_s;

	assign pins_raw = {plugboard_option_key, lamp_hub, stop_press, launch_press, local_clear_press,
		joint_clear_press, power_mode, char_check};

	level_sync #(.WIDTH(SW)) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	assign {keys_s, lamps_s, stop_s, launch_s, local_s, joint_s, pm_s, cc_s} = pins_s;

	////////////////////////////////////////////////////////////////////
	// startup delay

	logic power_all;
	logic delay_done;

	assign power_all = pm_s.power_translator & pm_s.power_io & pm_s.power_computer;

	startup_timer #(.CYCLES(STARTUP_CYCLES)) u_timer (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.clk_en     (clk_en),
		.power_good (power_all),
		.elapsed    (delay_done)
	);

	////////////////////////////////////////////////////////////////////
	// register bus decode

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	logic                          wr_en;
	logic                          rd_en;
	logic [3:0]                    ctl_pulse;
	logic [panel_pkg::IRQ_WIDTH-1:0] irq_clear_w;
	logic                          mapped;
	logic                          access;
	logic                          pready_r;
	logic                          pready_nxt;
	logic                          pslverr_r;
	logic                          pslverr_nxt;

	// one wait state so read data and error come from flops at the completing edge
	assign access   = psel & penable & clk_en;
	assign wr_en    = access & pwrite & pready_r;
	assign rd_en    = access & ~pwrite & ~pready_r;
	assign mapped   = hit(paddr, panel_pkg::ADDR_CONTROL) | hit(paddr, panel_pkg::ADDR_STATUS)
		| hit(paddr, panel_pkg::ADDR_IRQ_STAT) | hit(paddr, panel_pkg::ADDR_IRQ_CLEAR)
		| hit(paddr, panel_pkg::ADDR_IRQ_EN) | hit(paddr, panel_pkg::ADDR_KEYS);
	assign ctl_pulse   = (wr_en && hit(paddr, panel_pkg::ADDR_CONTROL)) ? pwdata[3:0] : 4'h0;
	assign irq_clear_w = (wr_en && hit(paddr, panel_pkg::ADDR_IRQ_CLEAR)) ?
		pwdata[panel_pkg::IRQ_WIDTH-1:0] : '0;

	////////////////////////////////////////////////////////////////////
	// panel press edges

	logic [3:0] press_r;
	logic [3:0] press_nxt;
	logic [3:0] press_now;
	logic [3:0] press_edge;

	assign press_now  = {joint_s, local_s, launch_s, stop_s};
	assign press_edge = (press_now & ~press_r) | ctl_pulse;

	always_comb begin
		press_nxt = clk_en ? press_now : press_r;
	end

	////////////////////////////////////////////////////////////////////
	// cycle control and status

	logic                           stop_ev;
	logic                           launch_ev;
	logic                           local_ev;
	logic                           joint_ev;
	logic                           clear_any;
	logic                           in_rdy;
	logic                           out_rdy;
	logic                           fault_any;
	logic                           parity_bad;
	logic                           untrans_ev;
	panel_pkg::cycle_state_t        state_r;
	panel_pkg::cycle_state_t        state_nxt;
	logic                           launch_lamp_r;
	logic                           launch_lamp_nxt;
	logic                           untrans_r;
	logic                           untrans_nxt;
	logic                           parity_r;
	logic                           parity_nxt;
	logic                           joint_lamp_r;
	logic                           joint_lamp_nxt;
	logic                           in_rdy_r;
	logic                           out_rdy_r;
	logic                           compare_r;
	logic [panel_pkg::HUB_COUNT-1:0]  hub_r;
	logic [panel_pkg::HUB_COUNT-1:0]  hub_nxt;
	logic [panel_pkg::LAMP_COUNT-1:0] lamp_r;
	logic [panel_pkg::IRQ_WIDTH-1:0]  irq_stat_r;
	logic [panel_pkg::IRQ_WIDTH-1:0]  irq_stat_nxt;
	logic [panel_pkg::IRQ_WIDTH-1:0]  irq_en_r;
	logic [panel_pkg::IRQ_WIDTH-1:0]  irq_en_nxt;
	logic [panel_pkg::IRQ_WIDTH-1:0]  irq_set;
	logic                           irq_r;
	logic [31:0]                    prdata_r;
	logic [31:0]                    prdata_nxt;

	assign stop_ev   = press_edge[panel_pkg::CTL_STOP_BIT];
	assign launch_ev = press_edge[panel_pkg::CTL_LAUNCH_BIT];
	assign local_ev  = press_edge[panel_pkg::CTL_LOCAL_BIT];
	assign joint_ev  = press_edge[panel_pkg::CTL_JOINT_BIT];
	assign clear_any = local_ev | joint_ev;

	// mode is chosen by plugboard; both selected counts as neither
	assign in_rdy  = pm_s.mode_input & ~pm_s.mode_output & power_all & delay_done;
	assign out_rdy = pm_s.mode_output & ~pm_s.mode_input & power_all & delay_done;

	assign parity_bad = cc_s.buffer_load & ~(^cc_s.buffer_char); // odd parity expected
	assign untrans_ev = cc_s.char_received & ~cc_s.decoder_hit & ~cc_s.delete_char
		& ~cc_s.precedence_char;
	assign fault_any  = untrans_r | parity_r | compare_r;

	// each key fans out to three adjacent hubs
	genvar g;
	generate
		for (g = 0; g < panel_pkg::HUB_COUNT; g++) begin : g_hub
			assign hub_nxt[g] = keys_s[g / panel_pkg::HUBS_PER_KEY];
		end
	endgenerate

	always_comb begin
		state_nxt       = state_r;
		launch_lamp_nxt = launch_lamp_r;
		untrans_nxt     = untrans_r;
		parity_nxt      = parity_r;
		joint_lamp_nxt  = joint_lamp_r;
		if (clear_any) begin
			state_nxt       = panel_pkg::CYCLE_IDLE;
			launch_lamp_nxt = 1'b0;
			untrans_nxt     = 1'b0;
			parity_nxt      = 1'b0;
			joint_lamp_nxt  = joint_ev;
		end else begin
			// joint clear lamp holds one cycle after the press
			joint_lamp_nxt = 1'b0;
			if (untrans_ev) begin
				untrans_nxt = 1'b1;
			end
			if (parity_bad) begin
				parity_nxt = 1'b1;
			end
			unique case (state_r)
				panel_pkg::CYCLE_IDLE: begin
					if (launch_ev && !joint_lamp_r && (in_rdy_r || out_rdy_r) && !fault_any) begin
						state_nxt       = panel_pkg::CYCLE_RUN;
						launch_lamp_nxt = 1'b1;
					end
				end
				panel_pkg::CYCLE_RUN: begin
					if (stop_ev) begin
						state_nxt       = panel_pkg::CYCLE_IDLE;
						launch_lamp_nxt = 1'b0;
					end
				end
			endcase
		end
	end

	assign irq_set = {(state_r == panel_pkg::CYCLE_RUN) && stop_ev, compare_r, parity_bad, untrans_ev};

	always_comb begin
		// set wins over clear
		irq_stat_nxt = (irq_stat_r & ~irq_clear_w) | irq_set;
		irq_en_nxt   = (wr_en && hit(paddr, panel_pkg::ADDR_IRQ_EN)) ? pwdata[panel_pkg::IRQ_WIDTH-1:0] : irq_en_r;
		prdata_nxt   = 32'h0;
		pready_nxt   = access & ~pready_r;
		pslverr_nxt  = access & ~pready_r & ~mapped;
		if (hit(paddr, panel_pkg::ADDR_STATUS)) begin
			prdata_nxt = {24'h0, parity_r, untrans_r, compare_r, out_rdy_r, in_rdy_r, joint_lamp_r,
				launch_lamp_r, state_r == panel_pkg::CYCLE_RUN};
		end else if (hit(paddr, panel_pkg::ADDR_IRQ_STAT)) begin
			prdata_nxt = {28'h0, irq_stat_r};
		end else if (hit(paddr, panel_pkg::ADDR_IRQ_EN)) begin
			prdata_nxt = {28'h0, irq_en_r};
		end else if (hit(paddr, panel_pkg::ADDR_KEYS)) begin
			prdata_nxt = {20'h0, lamp_r, keys_s};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			press_r       <= 4'h0;
			state_r       <= panel_pkg::CYCLE_IDLE;
			launch_lamp_r <= 1'b0;
			untrans_r     <= 1'b0;
			parity_r      <= 1'b0;
			joint_lamp_r  <= 1'b0;
			in_rdy_r      <= 1'b0;
			out_rdy_r     <= 1'b0;
			compare_r     <= 1'b0;
			hub_r         <= '0;
			lamp_r        <= '0;
			irq_stat_r    <= '0;
			irq_en_r      <= panel_pkg::IRQ_EN_RESET;
			irq_r         <= 1'b0;
			prdata_r      <= 32'h0;
			pready_r      <= 1'b0;
			pslverr_r     <= 1'b0;
		end else begin
			press_r <= press_nxt;
			if (clk_en) begin
				state_r       <= state_nxt;
				launch_lamp_r <= launch_lamp_nxt;
				untrans_r     <= untrans_nxt;
				parity_r      <= parity_nxt;
				joint_lamp_r  <= joint_lamp_nxt;
				in_rdy_r      <= in_rdy;
				out_rdy_r     <= out_rdy;
				compare_r     <= cc_s.compare_hub;
				hub_r         <= hub_nxt;
				lamp_r        <= lamps_s;
				irq_stat_r    <= irq_stat_nxt;
				irq_en_r      <= irq_en_nxt;
				irq_r         <= |(irq_stat_nxt & irq_en_nxt);
				pready_r      <= pready_nxt;
				pslverr_r     <= pslverr_nxt;
				if (rd_en) begin
					prdata_r <= prdata_nxt;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign option_hub          = hub_r;
	assign programmable_lamp   = lamp_r;
	assign launch_lamp         = launch_lamp_r;
	assign cycle_run           = state_r == panel_pkg::CYCLE_RUN;
	assign joint_clear_lamp    = joint_lamp_r;
	assign io_clear            = joint_lamp_r; // I/O unit clears only on joint clear
	assign input_ready         = in_rdy_r;
	assign output_ready        = out_rdy_r;
	assign compare_lamp        = compare_r;
	assign untranslatable_flag = untrans_r;
	assign parity_fault        = parity_r;
	assign irq                 = irq_r;
	assign prdata              = prdata_r;
	assign pready              = pready_r;
	assign pslverr             = pslverr_r;

endmodule

// *** verilog/panel_pkg.sv ***
// shared constants and carriers for the translator panel control
package panel_pkg;

	localparam int KEY_COUNT          = 6;
	localparam int HUB_COUNT          = 18;
	localparam int HUBS_PER_KEY       = 3;
	localparam int LAMP_COUNT         = 6;
	localparam int SYNC_STAGES        = 2;
	localparam int CHAR_WIDTH         = 8;
	localparam int IRQ_WIDTH          = 4;

	// startup delay after power is good, in microseconds
	localparam int STARTUP_DELAY_US   = 100;
	localparam int CLOCK_MHZ          = 125;
	localparam int STARTUP_CYCLES     = STARTUP_DELAY_US * CLOCK_MHZ;

	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
	localparam logic [7:0] ADDR_KEYS      = 8'h14;

	// control register bit positions, written as one-shot pulses
	localparam int CTL_STOP_BIT    = 0;
	localparam int CTL_LAUNCH_BIT  = 1;
	localparam int CTL_LOCAL_BIT   = 2;
	localparam int CTL_JOINT_BIT   = 3;

	// interrupt status bit positions
	localparam int IRQ_UNTRANS_BIT = 0;
	localparam int IRQ_PARITY_BIT  = 1;
	localparam int IRQ_COMPARE_BIT = 2;
	localparam int IRQ_STOPPED_BIT = 3;

	localparam logic [IRQ_WIDTH-1:0] IRQ_EN_RESET = 4'h0;

	typedef struct packed {
		logic mode_input;
		logic mode_output;
		logic power_translator;
		logic power_io;
		logic power_computer;
	} power_mode_t;

	typedef struct packed {
		logic                  char_received;
		logic                  decoder_hit;
		logic                  delete_char;
		logic                  precedence_char;
		logic                  buffer_load;
		logic [CHAR_WIDTH-1:0] buffer_char;
		logic                  compare_hub;
	} char_check_t;

	typedef enum logic [0:0] {
		CYCLE_IDLE,
		CYCLE_RUN
	} cycle_state_t;

endpackage

// *** verilog/level_sync.sv ***
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	always_comb begin
		meta_nxt = clk_en ? async_in : meta_r;
		sync_nxt = clk_en ? meta_r : sync_r;
	end

	// first stage feeds only the second
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule

// *** verilog/startup_timer.sv ***
// startup delay counter, restarts whenever power drops
`timescale 1ns/10ps
module startup_timer #(
	parameter int CYCLES = panel_pkg::STARTUP_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	input  wire logic power_good,
	output logic      elapsed
);

	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic        done_r;
	logic        done_nxt;

	always_comb begin
		count_nxt = count_r;
		done_nxt  = done_r;
		if (clk_en) begin
			if (!power_good) begin
				count_nxt = 32'h0;
				done_nxt  = 1'b0;
			end else if (!done_r) begin
				if (count_r >= 32'(CYCLES - 1)) begin
					done_nxt = 1'b1;
				end else begin
					count_nxt = count_r + 32'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_r <= 32'h0;
			done_r  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			done_r  <= done_nxt;
		end
	end

	assign elapsed = done_r;

endmodule

// *** testbench/panel_checker_sva.sv ***
// port-level assertions for the translator panel control
`timescale 1ns/10ps
module panel_checker #(
	parameter int STARTUP_CYCLES = 8
) (
	input wire logic                                  sys_clk,
	input wire logic                                  reset,
	input wire logic                                  clk_en,
	input wire logic [panel_pkg::KEY_COUNT-1:0]       plugboard_option_key,
	input wire logic [panel_pkg::HUB_COUNT-1:0]       option_hub,
	input wire logic [panel_pkg::LAMP_COUNT-1:0]      lamp_hub,
	input wire logic [panel_pkg::LAMP_COUNT-1:0]      programmable_lamp,
	input wire logic                                  stop_press,
	input wire panel_pkg::power_mode_t                power_mode,
	input wire panel_pkg::char_check_t                char_check,
	input wire logic                                  launch_lamp,
	input wire logic                                  cycle_run,
	input wire logic                                  joint_clear_lamp,
	input wire logic                                  io_clear,
	input wire logic                                  input_ready,
	input wire logic                                  output_ready,
	input wire logic                                  compare_lamp,
	input wire logic                                  untranslatable_flag,
	input wire logic                                  parity_fault
);
	logic [2:0] age_r;
	logic [2:0] age_nxt;
	logic       warm;
	logic       all_pwr;
	logic       bad_char;
	logic       bad_par;
	logic       gate;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset || !clk_en);

	function automatic logic [panel_pkg::HUB_COUNT-1:0] spread(input logic [panel_pkg::KEY_COUNT-1:0] k);
		logic [panel_pkg::HUB_COUNT-1:0] s;
		for (int i = 0; i < panel_pkg::HUB_COUNT; i++)
			s[i] = k[i / panel_pkg::HUBS_PER_KEY];
		return s;
	endfunction

	// pins reach outputs three edges late; reset and frozen cycles restart the count
	always_comb age_nxt = !clk_en ? 3'h0 : (age_r == 3'h7) ? age_r : age_r + 3'h1;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) age_r <= 3'h0;
		else age_r <= age_nxt;
	end
	assign warm     = age_r > 3'h3;
	assign all_pwr  = power_mode.power_translator & power_mode.power_io & power_mode.power_computer;
	assign bad_char = char_check.char_received & ~char_check.decoder_hit & ~char_check.delete_char
		& ~char_check.precedence_char;
	assign bad_par  = char_check.buffer_load & ~(^char_check.buffer_char);
	assign gate     = ~joint_clear_lamp & (input_ready | output_ready) & ~untranslatable_flag & ~parity_fault
		& ~compare_lamp;

	////////////////////////////////////////////////////////////////////////////////
	a_hub_route: assert property (warm |-> option_hub == spread($past(plugboard_option_key, 3)))
		else $error("option hubs do not follow keys");
	a_lamp_follow: assert property (warm |-> programmable_lamp == $past(lamp_hub, 3))
		else $error("lamp does not follow hub");
	a_stop_ends: assert property ($rose(stop_press) && cycle_run |-> ##[1:6] !cycle_run)
		else $error("cycle kept running after stop");
	a_launch_lamp: assert property ($rose(cycle_run) |-> launch_lamp)
		else $error("cycle started without launch lamp");
	a_launch_gate: assert property ($rose(cycle_run) |-> $past(gate))
		else $error("cycle started while blocked");
	a_joint_pulse: assert property (io_clear |-> joint_clear_lamp ##1 !io_clear)
		else $error("joint clear pulse malformed");
	a_in_cause: assert property ($rose(input_ready)
		|-> $past(power_mode.mode_input & ~power_mode.mode_output & all_pwr, 3))
		else $error("input ready without its conditions");
	a_out_cause: assert property ($rose(output_ready)
		|-> $past(power_mode.mode_output & ~power_mode.mode_input & all_pwr, 3))
		else $error("output ready without its conditions");
	a_compare_follow: assert property (warm |-> compare_lamp == $past(char_check.compare_hub, 3))
		else $error("compare lamp does not follow hub");
	a_untrans_set: assert property (warm && $past(bad_char, 3) |-> ##[0:1] untranslatable_flag)
		else $error("untranslatable char not flagged");
	a_parity_set: assert property (warm && $past(bad_par, 3) |-> ##[0:1] parity_fault)
		else $error("parity failure not flagged");
	a_ready_excl: assert property (!(input_ready && output_ready))
		else $error("both ready flags high");

	c_run: cover property ($rose(cycle_run));
	c_joint: cover property (io_clear);
	c_parity: cover property ($rose(parity_fault));
endmodule

// *** testbench/io_plugboard_model.sv ***
// plugboard wiring and I/O control unit stand-in
`timescale 1ns/10ps
module io_plugboard_model (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              io_clear,
	input  wire logic              power_on,
	input  wire logic [1:0]        mode_sel,
	input  wire logic [5:0]        lamp_choice,
	output panel_pkg::power_mode_t power_mode,
	output logic      [5:0]        lamp_hub,
	output logic      [7:0]        clear_cnt
);
	logic [7:0] clear_cnt_r;
	logic [7:0] clear_cnt_nxt;

	// programmer-chosen signals wired straight onto the lamp hubs
	assign lamp_hub = lamp_choice;
	// one on switch feeds translator, I/O unit and computer; mode_sel 3 only when a test asks
	assign power_mode = '{mode_sel[0], mode_sel[1], power_on, power_on, power_on};
	// I/O unit returns to its initial state on each joint clear, counted here
	always_comb clear_cnt_nxt = io_clear ? clear_cnt_r + 8'h01 : clear_cnt_r;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) clear_cnt_r <= 8'h00;
		else clear_cnt_r <= clear_cnt_nxt;
	end
	assign clear_cnt = clear_cnt_r;
endmodule

// *** testbench/translator_panel_control_tb_top.sv ***
// self-checking bench for the translator panel control
`timescale 1ns/10ps
module translator_panel_control_tb_top;
	typedef struct packed {
		logic [5:0]  key;
		logic [5:0]  lamp;
		logic [17:0] hub;
	} row_t;
	localparam int STARTUP_CYCLES = 8;
	row_t        rows [7] = '{'{6'h01, 6'h20, 18'h00007}, '{6'h02, 6'h10, 18'h00038}, '{6'h04, 6'h08, 18'h001C0},
		'{6'h08, 6'h04, 18'h00E00}, '{6'h10, 6'h02, 18'h07000}, '{6'h20, 6'h01, 18'h38000}, '{6'h3F, 6'h3F, 18'h3FFFF}};
	logic        sys_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, irq, power_on;
	logic        launch_lamp, cycle_run, joint_clear_lamp, io_clear, input_ready, output_ready;
	logic        compare_lamp, untranslatable_flag, parity_fault;
	logic [1:0]  mode_sel;
	logic [3:0]  btn;
	logic [5:0]  plugboard_option_key, lamp_choice, lamp_hub, programmable_lamp;
	logic [7:0]  paddr, clear_cnt;
	logic [13:0] quiet [4] = '{14'h3000, 14'h2800, 14'h2400, 14'h020E};
	logic [17:0] option_hub;
	logic [31:0] pwdata, prdata;
	int          error_cnt = 0, num_checks = 0;
	panel_pkg::power_mode_t power_mode;
	panel_pkg::char_check_t cc;

	translator_panel_control #(.STARTUP_CYCLES(STARTUP_CYCLES)) DUT (
		.sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.plugboard_option_key, .option_hub, .lamp_hub, .programmable_lamp,
		.stop_press(btn[0]), .launch_press(btn[1]), .local_clear_press(btn[2]), .joint_clear_press(btn[3]),
		.power_mode, .char_check(cc), .launch_lamp, .cycle_run, .joint_clear_lamp, .io_clear,
		.input_ready, .output_ready, .compare_lamp, .untranslatable_flag, .parity_fault, .irq
	);
	io_plugboard_model partner (.sys_clk, .reset, .io_clear, .power_on, .mode_sel, .lamp_choice, .power_mode,
		.lamp_hub, .clear_cnt);

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// pready, pslverr and read data are all taken at the edge that completes the access
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		e = pslverr;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		check(r, x);
	endtask
	// panel keys are held long enough to pass the two-stage synchroniser
	task automatic press(input int b);
		@(posedge sys_clk);
		btn[b] <= 1'b1;
		tick(4);
		@(posedge sys_clk);
		btn <= 4'h0;
		tick(5);
	endtask
	task automatic ev(input logic [13:0] v);
		@(posedge sys_clk);
		cc <= v;
		tick(4);
		@(posedge sys_clk);
		cc <= '0;
		tick(4);
	endtask
	task automatic wait_rdy(input logic want_out);
		int i;
		i = 0;
		while (((want_out ? output_ready : input_ready) !== 1'b1) && i < 200) begin
			tick(1);
			i++;
		end
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		conclude();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		reset = 1'b1; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		plugboard_option_key = 6'h00; lamp_choice = 6'h00; btn = 4'h0; cc = '0; mode_sel = 2'h0; power_on = 1'b0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		tick(2);
		check(32'({cycle_run, launch_lamp, input_ready, output_ready, parity_fault, irq}), 32'h0);
		rd_chk(panel_pkg::ADDR_IRQ_EN, 32'h0);
		apb(8'h20, 1'b0, 32'h0, r, e);
		check(32'(e), 32'h1);
		check(r, 32'h0);
		foreach (rows[i]) begin
			@(posedge sys_clk);
			plugboard_option_key <= rows[i].key;
			lamp_choice <= rows[i].lamp;
			tick(5);
			check(32'(option_hub), 32'(rows[i].hub));
			check(32'(programmable_lamp), 32'(rows[i].lamp));
			rd_chk(panel_pkg::ADDR_KEYS, 32'({rows[i].lamp, rows[i].key}));
		end
		press(1);
		check(32'(cycle_run), 32'h0);
		@(posedge sys_clk);
		power_on <= 1'b1;
		mode_sel <= 2'h1;
		wait_rdy(1'b0);
		check(32'({input_ready, output_ready}), 32'h2);
		wr(panel_pkg::ADDR_IRQ_EN, 32'hF);
		press(1);
		check(32'({cycle_run, launch_lamp}), 32'h3);
		rd_chk(panel_pkg::ADDR_STATUS, 32'h0B);
		press(0);
		check(32'(cycle_run), 32'h0);
		rd_chk(panel_pkg::ADDR_IRQ_STAT, 32'h8);
		check(32'(irq), 32'h1);
		wr(panel_pkg::ADDR_IRQ_CLEAR, 32'h8);
		tick(2);
		check(32'(irq), 32'h0);
		@(posedge sys_clk);
		mode_sel <= 2'h3;
		tick(6);
		check(32'({input_ready, output_ready}), 32'h0);
		@(posedge sys_clk);
		mode_sel <= 2'h2;
		wait_rdy(1'b1);
		check(32'({input_ready, output_ready}), 32'h1);
		foreach (quiet[i]) begin
			ev(quiet[i]);
			check(32'({untranslatable_flag, parity_fault}), 32'h0);
		end
		ev(14'h2000);
		check(32'(untranslatable_flag), 32'h1);
		press(1);
		check(32'(cycle_run), 32'h0);
		press(2);
		check(32'({untranslatable_flag, clear_cnt}), 32'h0);
		press(1);
		check(32'(cycle_run), 32'h1);
		press(2);
		check(32'(cycle_run), 32'h0);
		ev(14'h0206);
		check(32'(parity_fault), 32'h1);
		wr(panel_pkg::ADDR_CONTROL, 32'h8);
		tick(3);
		check(32'({parity_fault, clear_cnt}), 32'h1);
		wr(panel_pkg::ADDR_CONTROL, 32'h2);
		tick(3);
		check(32'(cycle_run), 32'h1);
		wr(panel_pkg::ADDR_CONTROL, 32'h1);
		tick(3);
		check(32'(cycle_run), 32'h0);
		@(posedge sys_clk);
		cc <= 14'h0001;
		tick(5);
		check(32'(compare_lamp), 32'h1);
		rd_chk(panel_pkg::ADDR_IRQ_STAT, 32'hF);
		press(1);
		check(32'(cycle_run), 32'h0);
		wr(panel_pkg::ADDR_IRQ_EN, 32'h4);
		tick(2);
		check(32'(irq), 32'h1);
		wr(panel_pkg::ADDR_IRQ_EN, 32'h0);
		tick(2);
		check(32'(irq), 32'h0);
		@(posedge sys_clk);
		cc <= '0;
		tick(5);
		check(32'(compare_lamp), 32'h0);
		// frozen clock enable must hold the lamps at their old value
		@(posedge sys_clk);
		clk_en <= 1'b0;
		lamp_choice <= 6'h15;
		tick(5);
		check(32'(programmable_lamp), 32'h3F);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		tick(5);
		check(32'(programmable_lamp), 32'h15);
		conclude();
	end
endmodule

bind translator_panel_control panel_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
	.sys_clk, .reset, .clk_en, .plugboard_option_key, .option_hub, .lamp_hub, .programmable_lamp, .stop_press,
	.power_mode, .char_check, .launch_lamp, .cycle_run, .joint_clear_lamp, .io_clear, .input_ready,
	.output_ready, .compare_lamp, .untranslatable_flag, .parity_fault
);
